// File: hdl/dlb_pkg.sv
// Shared constants and types for the DMA local bus master/slave port
package dlb_pkg;
	localparam int            DLB_NUM_CH      = 8;
	localparam int            DLB_ADDR_W      = 30;
	localparam int            DLB_DATA_W      = 32;
	localparam int            DLB_LANES       = 4;
	localparam int            DLB_SHARED_CH   = 4;
	localparam int            DLB_SYNC_W      = 14;
	// Positions inside the synchroniser vector
	localparam int            DLB_SY_READY    = 0;
	localparam int            DLB_SY_ADS      = 1;
	localparam int            DLB_SY_NA       = 2;
	localparam int            DLB_SY_GRANT    = 3;
	localparam int            DLB_SY_WR       = 4;
	localparam int            DLB_SY_SEL      = 5;
	localparam int            DLB_SY_REQ      = 6;
	// Reset values
	localparam logic          DLB_RST_REQ     = 1'b0;
	localparam logic          DLB_RST_STROBE  = 1'b1;
	localparam logic          DLB_RST_PHASE   = 1'b0;
	localparam logic [3:0]    DLB_RST_BE_N    = 4'hF;
	// Pins at rest: strobes and ready high, shared channel 4 pin pulled high, requests low
	localparam logic [13:0]   DLB_RST_SYNC    = 14'h0407;
	localparam logic [2:0]    DLB_RST_CH      = 3'h0;

	typedef enum logic [2:0] {
		DLB_IDLE    = 3'b000,
		DLB_REQ     = 3'b001,
		DLB_ADDR    = 3'b011,
		DLB_DATA    = 3'b010,
		DLB_RELEASE = 3'b110
	} dlb_state_e;
endpackage

// File: hdl/dlb_port.sv
// Local bus master/slave port: bus request, arbitration, pin drive control
// Functional notes
// - Address lines driven only in master mode, otherwise released.
// - Byte select n qualifies byte lane n; all active low.
// - Byte selects are outputs only in master mode, inputs otherwise.
// - Data driven only for interrupt acknowledge, slave reads, or master writes.
// - Logic runs on double-rate clock and tracks its phase.
// - Cycle-type lines driven in master mode; only write/read sampled as input in slave.
// - Master asserts address strobe in first valid bus state only.
// - Next-address input sampled only while master.
// - Slave pipelining decided from current and previous strobe and ready.
// - Bus request held high while mastership is needed.
// - Eight active-high requests, synchronised, arbitrated by priority.
// - Fixed priority after reset, channel 0 highest, 7 lowest.
// - Channel 4 pin also feeds active-low interrupt 9, edge or level.
// - DMA and interrupt uses of shared pin masked independently.
// - Floating shared pin reads DMA request active, interrupt inactive.
// - Ready input sampled in both master and slave modes.
// - Reset leaves slave mode with master outputs inactive.
module dlb_port
	import dlb_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	// Local bus pins
	output logic [DLB_ADDR_W-1:0]        doubleword_addr_lines_out,
	output logic                         doubleword_addr_lines_oe,
	output logic [DLB_LANES-1:0]         lane_byte_sel_n_out,
	output logic                         lane_byte_sel_n_oe,
	input  wire logic [DLB_LANES-1:0]    lane_byte_sel_n_in,
	output logic [DLB_DATA_W-1:0]        bus_data_lines_out,
	output logic                         bus_data_lines_oe,
	input  wire logic [DLB_DATA_W-1:0]   bus_data_lines_in,
	output logic                         data_ctrl_sel_out,
	output logic                         write_read_sel_out,
	output logic                         mem_io_sel_out,
	output logic                         cycle_type_oe,
	input  wire logic                    write_read_sel_in,
	output logic                         addr_strobe_n_out,
	output logic                         addr_strobe_n_oe,
	input  wire logic                    addr_strobe_n_in,
	input  wire logic                    pipeline_next_addr_n,
	input  wire logic                    ready_n,
	output logic                         bus_request,
	input  wire logic                    bus_grant_in,
	input  wire logic                    slave_select,
	input  wire logic [3:0]              channel_transfer_request_lo,
	input  wire logic [2:0]              channel_transfer_request_hi,
	input  wire logic                    ch4_request_or_irq9_pin,
	// Controller side
	input  wire logic [DLB_NUM_CH-1:0]   dma_mask,
	input  wire logic                    irq9_mask,
	input  wire logic                    irq9_edge_mode,
	input  wire logic                    irq9_clear,
	output logic                         irq9_request,
	output logic                         channel_pending,
	output logic [2:0]                   active_channel,
	input  wire logic                    xfer_valid,
	input  wire logic [DLB_ADDR_W-1:0]   xfer_addr,
	input  wire logic [DLB_LANES-1:0]    xfer_byte_sel_n,
	input  wire logic                    xfer_write,
	input  wire logic                    xfer_mem,
	input  wire logic                    xfer_data_ctrl,
	input  wire logic [DLB_DATA_W-1:0]   xfer_wdata,
	output logic                         xfer_done,
	output logic [DLB_DATA_W-1:0]        xfer_rdata,
	output logic                         next_addr_seen,
	input  wire logic                    intack_cycle,
	input  wire logic [DLB_DATA_W-1:0]   slave_rdata,
	output logic                         slave_pipelined,
	output logic                         bus_phase
);
	// Two-stage synchronisers for every pin input that steers logic
	logic [DLB_SYNC_W-1:0] sy1_q, sy2_q;
	wire  [DLB_SYNC_W-1:0] sy_raw = {channel_transfer_request_hi, ch4_request_or_irq9_pin,
		channel_transfer_request_lo, slave_select, write_read_sel_in, bus_grant_in,
		pipeline_next_addr_n, addr_strobe_n_in, ready_n};
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sy1_q <= DLB_RST_SYNC;
			sy2_q <= DLB_RST_SYNC;
		end else begin
			sy1_q <= sy_raw;
			sy2_q <= sy1_q;
		end
	end

	wire                  rdy_s   = ~sy2_q[DLB_SY_READY];
	wire                  ads_s   = ~sy2_q[DLB_SY_ADS];
	wire                  na_s    = ~sy2_q[DLB_SY_NA];
	wire                  grant_s = sy2_q[DLB_SY_GRANT];
	wire                  wr_s    = sy2_q[DLB_SY_WR];
	wire                  sel_s   = sy2_q[DLB_SY_SEL];
	wire [DLB_NUM_CH-1:0] req_s   = sy2_q[DLB_SY_REQ +: DLB_NUM_CH];
	// A floating shared pin is pulled high: DMA sees a request, interrupt sees none
	wire                  irq_lvl = ~req_s[DLB_SHARED_CH];

	// Fixed priority: lowest index wins
	wire [DLB_NUM_CH-1:0] elig = req_s & ~dma_mask;
	logic [2:0]           win_ch;
	always_comb begin
		win_ch = DLB_RST_CH;
		for (int i = DLB_NUM_CH - 1; i >= 0; i--) begin
			if (elig[i]) begin
				win_ch = 3'(i);
			end
		end
	end
	wire any_req = |elig;

	// Phase of the double-rate clock; a bus state spans two edges
	logic phase_q;
	logic ads_prev_q;
	wire  ads_fall = ads_s & ~ads_prev_q;
	wire  tick     = phase_q;

	dlb_state_e state_q, state_d;
	wire master = (state_q == DLB_ADDR) || (state_q == DLB_DATA);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			DLB_IDLE:    if (any_req) state_d = DLB_REQ;
			DLB_REQ:     if (!any_req) state_d = DLB_RELEASE;
				else if (grant_s && tick && xfer_valid) state_d = DLB_ADDR;
			DLB_ADDR:    if (tick) state_d = DLB_DATA;
			DLB_DATA:    if (tick && rdy_s) begin
				state_d = (any_req && xfer_valid && grant_s) ? DLB_ADDR : DLB_RELEASE;
			end
			DLB_RELEASE: state_d = DLB_IDLE;
			default:     state_d = DLB_IDLE;
		endcase
	end

	// Slave side: a new strobe while the last cycle is still open is pipelined
	logic cyc_open_q;
	wire  slv_strobe = ~master && ads_fall;
	wire  slv_read   = ~master && sel_s && ~wr_s && (ads_s || cyc_open_q);
	wire  done_d     = (state_q == DLB_DATA) && tick && rdy_s;

	wire                  drive_d  = (state_d == DLB_ADDR) || (state_d == DLB_DATA);
	wire                  data_oe_d = (drive_d && xfer_write) || slv_read || intack_cycle;
	wire [DLB_DATA_W-1:0] data_d   = drive_d ? xfer_wdata : slave_rdata;

	logic irq_prev_q;
	wire  irq_edge = irq_lvl & ~irq_prev_q;
	wire  irq_set  = irq9_edge_mode ? irq_edge : irq_lvl;
	wire  irq_d    = irq9_mask ? 1'b0 : (irq_set | (irq9_edge_mode & irq9_request & ~irq9_clear));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q                   <= DLB_IDLE;
			phase_q                   <= DLB_RST_PHASE;
			ads_prev_q                <= 1'b0;
			cyc_open_q                <= 1'b0;
			irq_prev_q                <= 1'b0;
			bus_request               <= DLB_RST_REQ;
			doubleword_addr_lines_out <= '0;
			doubleword_addr_lines_oe  <= 1'b0;
			lane_byte_sel_n_out       <= DLB_RST_BE_N;
			lane_byte_sel_n_oe        <= 1'b0;
			bus_data_lines_out        <= '0;
			bus_data_lines_oe         <= 1'b0;
			data_ctrl_sel_out         <= 1'b0;
			write_read_sel_out        <= 1'b0;
			mem_io_sel_out            <= 1'b0;
			cycle_type_oe             <= 1'b0;
			addr_strobe_n_out         <= DLB_RST_STROBE;
			addr_strobe_n_oe          <= 1'b0;
			irq9_request              <= 1'b0;
			channel_pending           <= 1'b0;
			active_channel            <= DLB_RST_CH;
			xfer_done                 <= 1'b0;
			xfer_rdata                <= '0;
			next_addr_seen            <= 1'b0;
			slave_pipelined           <= 1'b0;
			bus_phase                 <= DLB_RST_PHASE;
		end else begin
			state_q                   <= state_d;
			// Realign to the processor when its strobe shows a new bus state
			phase_q                   <= slv_strobe ? 1'b0 : ~phase_q;
			bus_phase                 <= slv_strobe ? 1'b0 : ~phase_q;
			ads_prev_q                <= ads_s;
			cyc_open_q                <= ads_s | (cyc_open_q & ~rdy_s);
			irq_prev_q                <= irq_lvl;
			bus_request               <= (state_d != DLB_IDLE) && (state_d != DLB_RELEASE);
			doubleword_addr_lines_out <= drive_d ? xfer_addr : doubleword_addr_lines_out;
			doubleword_addr_lines_oe  <= drive_d;
			lane_byte_sel_n_out       <= drive_d ? xfer_byte_sel_n : DLB_RST_BE_N;
			lane_byte_sel_n_oe        <= drive_d;
			bus_data_lines_out        <= data_d;
			bus_data_lines_oe         <= data_oe_d;
			data_ctrl_sel_out         <= drive_d & xfer_data_ctrl;
			write_read_sel_out        <= drive_d & xfer_write;
			mem_io_sel_out            <= drive_d & xfer_mem;
			cycle_type_oe             <= drive_d;
			addr_strobe_n_out         <= ~(state_d == DLB_ADDR);
			addr_strobe_n_oe          <= drive_d;
			irq9_request              <= irq_d;
			channel_pending           <= any_req;
			active_channel            <= win_ch;
			xfer_done                 <= done_d;
			xfer_rdata                <= done_d ? bus_data_lines_in : xfer_rdata;
			next_addr_seen            <= master & na_s;
			slave_pipelined           <= slv_strobe & cyc_open_q & ~rdy_s;
		end
	end

	// Byte selects arrive from the processor in slave mode; not decoded here, only reduced into an unused wire
	wire unused_be = &lane_byte_sel_n_in;

	a_addr_only_master: assert property (@(posedge core_clk) disable iff (!rst_b)
		doubleword_addr_lines_oe |-> $past(state_d == DLB_ADDR || state_d == DLB_DATA))
		else $error("address driven outside master mode");
	a_be_with_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
		lane_byte_sel_n_oe == doubleword_addr_lines_oe && cycle_type_oe == lane_byte_sel_n_oe)
		else $error("byte select or cycle type drive differs from address drive");
	a_data_drive_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_data_lines_oe |-> $past(drive_d || slv_read || intack_cycle))
		else $error("data driven without cause");
	a_strobe_first_state: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(addr_strobe_n_out) |=> ##1 $rose(addr_strobe_n_out) or ##1 !addr_strobe_n_out ##1
		$rose(addr_strobe_n_out))
		else $error("address strobe not a single bus state");
	a_strobe_needs_oe: assert property (@(posedge core_clk) disable iff (!rst_b)
		!addr_strobe_n_out |-> addr_strobe_n_oe)
		else $error("strobe asserted while released");
	a_master_needs_grant: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state_q == DLB_REQ) ##1 (state_q == DLB_ADDR) |-> $past(grant_s))
		else $error("master mode without grant");
	a_request_held: assert property (@(posedge core_clk) disable iff (!rst_b)
		doubleword_addr_lines_oe |-> bus_request)
		else $error("bus request dropped while master");
	a_priority_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
		elig[0] |=> active_channel == 3'h0)
		else $error("channel 0 not highest priority");
	a_na_slave_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
		!master |=> !next_addr_seen)
		else $error("next address seen outside master mode");
	a_release_path: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state_q == DLB_RELEASE) |=> !bus_request && !doubleword_addr_lines_oe)
		else $error("bus not released");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_b)
		irq9_mask |=> !irq9_request)
		else $error("masked interrupt 9 raised");
endmodule // dlb_port

// File: verification/dlb_host_model.sv
// Host processor model: hands over the bus and completes master cycles
module dlb_host_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic bus_request,
	input  wire logic addr_strobe_n,
	output logic      bus_grant_in,
	output logic      ready_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_grant_in <= 1'b0;
			wait_q       <= 3'h0;
		end else begin
			// Grant trails the request by a cycle, with no check of the host's own strobe
			bus_grant_in <= bus_request;
			if (!addr_strobe_n)
				wait_q <= 3'h6;
			else if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
		end
	end
	// Four low cycles so that one phase-1 sample always sees ready
	assign ready_n = !(wait_q inside {[3'h1:3'h4]});
endmodule // dlb_host_model

// File: verification/dlb_port_tb.sv
// Self-checking bench for the local bus master/slave port
module dlb_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dlb_pkg::*;
	logic core_clk = 0, rst_b = 0, tb_ads_n = 1, tb_ready_n = 1, tb_wr = 0, slave_select = 0;
	logic [3:0] channel_transfer_request_lo = 0, lane_byte_sel_n_out, xfer_byte_sel_n = 4'hF;
	logic [2:0] channel_transfer_request_hi = 0, active_channel;
	logic ch4_request_or_irq9_pin = 1, irq9_mask = 0, irq9_edge_mode = 0, irq9_clear = 0;
	logic [7:0] dma_mask = 8'h10;
	logic xfer_valid = 0, xfer_write = 0, xfer_mem = 0, xfer_data_ctrl = 0, intack_cycle = 0;
	logic pipeline_next_addr_n = 1, host_ready_n, bus_grant_in, bus_request, xfer_done;
	logic [29:0] xfer_addr = 0, doubleword_addr_lines_out;
	logic [31:0] xfer_wdata = 0, slave_rdata = 0, bus_data_lines_out, xfer_rdata;
	logic doubleword_addr_lines_oe, lane_byte_sel_n_oe, bus_data_lines_oe, data_ctrl_sel_out;
	logic write_read_sel_out, mem_io_sel_out, cycle_type_oe, addr_strobe_n_out, addr_strobe_n_oe;
	logic irq9_request, channel_pending, next_addr_seen, slave_pipelined, bus_phase;
	int n_fail = 0, check_count = 0, i;
	// Held-high byte select is low only while reset is applied
	wire [3:0] lane_byte_sel_n_in = lane_byte_sel_n_oe ? lane_byte_sel_n_out : {rst_b, 3'h7};
	wire addr_strobe_n_in = addr_strobe_n_oe ? addr_strobe_n_out : tb_ads_n;
	wire write_read_sel_in = cycle_type_oe ? write_read_sel_out : tb_wr;
	wire ready_n = host_ready_n & tb_ready_n;
	// Released data bus shows the inverse of the last value, never a stale copy
	wire [31:0] bus_data_lines_in = bus_data_lines_oe ? bus_data_lines_out : ~bus_data_lines_out;
	always #20 core_clk = ~core_clk;
	dlb_port u_dlb_port (.core_clk, .rst_b, .doubleword_addr_lines_out, .doubleword_addr_lines_oe,
		.lane_byte_sel_n_out, .lane_byte_sel_n_oe, .lane_byte_sel_n_in, .bus_data_lines_out,
		.bus_data_lines_oe, .bus_data_lines_in, .data_ctrl_sel_out, .write_read_sel_out,
		.mem_io_sel_out, .cycle_type_oe, .write_read_sel_in, .addr_strobe_n_out,
		.addr_strobe_n_oe, .addr_strobe_n_in, .pipeline_next_addr_n, .ready_n, .bus_request,
		.bus_grant_in, .slave_select, .channel_transfer_request_lo, .channel_transfer_request_hi,
		.ch4_request_or_irq9_pin, .dma_mask, .irq9_mask, .irq9_edge_mode, .irq9_clear,
		.irq9_request, .channel_pending, .active_channel, .xfer_valid, .xfer_addr,
		.xfer_byte_sel_n, .xfer_write, .xfer_mem, .xfer_data_ctrl, .xfer_wdata, .xfer_done,
		.xfer_rdata, .next_addr_seen, .intack_cycle, .slave_rdata, .slave_pipelined, .bus_phase);
	dlb_host_model u_dlb_host_model (.core_clk, .rst_b, .bus_request,
		.addr_strobe_n(addr_strobe_n_in), .bus_grant_in, .ready_n(host_ready_n));
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task t_reset;
		@(negedge core_clk);
		check("oe", {doubleword_addr_lines_oe, lane_byte_sel_n_oe, bus_data_lines_oe,
			cycle_type_oe, addr_strobe_n_oe, bus_request}, 6'h00);
		check("idle", {addr_strobe_n_out, lane_byte_sel_n_out}, 5'h1F);
		i = bus_phase;
		@(negedge core_clk) check("phase", bus_phase, !i[0]);
	endtask
	task t_prio;
		@(posedge core_clk);
		channel_transfer_request_hi <= 3'h1;
		channel_transfer_request_lo <= 4'h4;
		repeat (5) @(negedge core_clk);
		check("winner", {channel_pending, active_channel}, 4'hA);
		check("hold", bus_request, 1'b1);
		@(posedge core_clk) dma_mask <= 8'h14;
		// Winner follows the mask one edge later
		@(negedge core_clk);
		repeat (5) @(negedge core_clk) check("masked", active_channel, 3'h5);
		@(posedge core_clk) channel_transfer_request_hi <= 3'h0;
		channel_transfer_request_lo <= 4'h0;
		dma_mask <= 8'h10;
		repeat (8) @(negedge core_clk);
		check("drop", {bus_request, channel_pending}, 2'h0);
	endtask
	task t_master;
		@(posedge core_clk);
		{channel_transfer_request_lo, xfer_valid, xfer_write, xfer_mem, xfer_data_ctrl} <= 8'h1F;
		{xfer_addr, xfer_byte_sel_n, xfer_wdata} <= {30'h1234567, 4'h3, 32'hCAFE0001};
		pipeline_next_addr_n <= 1'b0;
		for (i = 0; i < 40 && addr_strobe_n_out !== 1'b0; i++) @(negedge core_clk);
		check("strobe", {addr_strobe_n_oe, addr_strobe_n_out}, 2'h2);
		check("addr", {doubleword_addr_lines_oe, doubleword_addr_lines_out}, 31'h41234567);
		check("lanes", {lane_byte_sel_n_oe, lane_byte_sel_n_out}, 5'h13);
		check("type", {cycle_type_oe, data_ctrl_sel_out, write_read_sel_out, mem_io_sel_out},
			4'hF);
		repeat (2) @(negedge core_clk);
		check("wdata", {bus_data_lines_oe, bus_data_lines_out}, 33'h1CAFE0001);
		for (i = 0; i < 40 && xfer_done !== 1'b1; i++) @(negedge core_clk);
		check("done", {xfer_done, next_addr_seen}, 2'h3);
		@(posedge core_clk) {channel_transfer_request_lo, xfer_valid} <= 5'h00;
		// A back-to-back cycle was already launched at the done edge; it ends first
		repeat (10) @(negedge core_clk);
		check("release", {bus_request, doubleword_addr_lines_oe, addr_strobe_n_oe,
			bus_data_lines_oe}, 4'h0);
		// Master read: the released bus shows the inverse of the last write data
		@(posedge core_clk) {channel_transfer_request_lo, xfer_valid, xfer_write} <= 6'h06;
		for (i = 0; i < 40 && xfer_done !== 1'b1; i++) @(negedge core_clk);
		check("rdata", {xfer_done, bus_data_lines_oe, xfer_rdata}, 34'h23501FFFE);
		@(posedge core_clk) {channel_transfer_request_lo, xfer_valid} <= 5'h00;
		repeat (10) @(negedge core_clk);
	endtask
	task t_irq;
		@(posedge core_clk) ch4_request_or_irq9_pin <= 1'b0;
		repeat (5) @(negedge core_clk);
		check("irq lvl", {irq9_request, channel_pending, next_addr_seen}, 3'h4);
		@(posedge core_clk) irq9_mask <= 1'b1;
		@(negedge core_clk);
		repeat (4) @(negedge core_clk) check("irq mask", irq9_request, 1'b0);
		@(posedge core_clk) {irq9_mask, irq9_edge_mode, ch4_request_or_irq9_pin} <= 3'h3;
		repeat (4) @(posedge core_clk);
		ch4_request_or_irq9_pin <= 1'b0;
		repeat (4) @(posedge core_clk);
		ch4_request_or_irq9_pin <= 1'b1;
		repeat (4) @(negedge core_clk) check("irq edge", irq9_request, 1'b1);
		@(posedge core_clk) {irq9_clear, dma_mask} <= 9'h100;
		@(posedge core_clk) irq9_clear <= 1'b0;
		repeat (5) @(negedge core_clk);
		check("float", {irq9_request, channel_pending, active_channel}, 5'h0C);
		@(posedge core_clk) {dma_mask, irq9_edge_mode} <= 9'h020;
	endtask
	task t_slave;
		@(posedge core_clk) {slave_select, tb_ads_n, slave_rdata} <= {2'h2, 32'h5A5A0FF0};
		@(posedge core_clk) tb_ads_n <= 1'b1;
		// Second strobe lands before the host's ready, so it is pipelined
		@(posedge core_clk) tb_ads_n <= 1'b0;
		@(posedge core_clk) tb_ads_n <= 1'b1;
		@(negedge core_clk);
		for (i = 0; i < 20 && bus_data_lines_oe !== 1'b1; i++) @(negedge core_clk);
		check("sread", {bus_data_lines_out, doubleword_addr_lines_oe}, 33'h0B4B41FE0);
		for (i = 0; i < 10 && slave_pipelined !== 1'b1; i++) @(negedge core_clk);
		check("pipe", slave_pipelined, 1'b1);
		// Select still high: only ready may end the read drive
		@(posedge core_clk) tb_ready_n <= 1'b0;
		repeat (5) @(negedge core_clk);
		check("sfree", bus_data_lines_oe, 1'b0);
		@(posedge core_clk) {tb_wr, tb_ads_n, tb_ready_n} <= 3'h5;
		@(posedge core_clk) tb_ads_n <= 1'b1;
		repeat (4) @(negedge core_clk) check("swrite", bus_data_lines_oe, 1'b0);
		@(posedge core_clk) {slave_select, tb_wr, intack_cycle} <= 3'h1;
		repeat (2) @(negedge core_clk);
		check("intack", {bus_data_lines_oe, bus_data_lines_out}, 33'h15A5A0FF0);
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_prio();
		t_master();
		t_irq();
		t_slave();
		report_and_stop();
	end
	initial begin
		#80000;
		n_fail++;
		report_and_stop();
	end
endmodule // dlb_port_tb
